// >>> hw/strap_cfg_pkg.sv
// constants shared by the strap configuration loader and its strap sampler
// assumes a 100 MHz system clock and a command-level register port
`default_nettype none

package strap_cfg_pkg;

	// clock and strap settling time
	localparam int CLK_PERIOD_NS       = 10;
	localparam int STRAP_SETTLE_NS     = 1000;  // settling wait before sampling
	localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// command codes of the two registers
	localparam logic [7:0] CMD_STACK_ROLE_CONFIG    = 8'hd6;
	localparam logic [7:0] CMD_STRAP_OVERRIDE       = 8'hd8;

	// stack_role_config layout
	localparam int         STK_RAW_LSB              = 4;
	localparam int         STK_POS_LSB              = 2;
	localparam int         STK_CNT_LSB              = 0;
	localparam logic [3:0] STK_RAW_RESET            = 4'h0;

	// strap_override_control layout
	localparam int          OVR_W                   = 16;
	localparam int          BIT_ROLE                = 15;
	localparam int          BIT_SOFT_START          = 11;
	localparam int          BIT_FAULT_ACTION        = 10;
	localparam int          BIT_BUS_ADDR            = 9;
	localparam int          BIT_LIGHT_LOAD          = 6;
	localparam int          BIT_SWITCH_FREQ         = 5;
	localparam int          BIT_RAMP                = 4;
	localparam int          BIT_LOOP_GAIN           = 3;
	localparam int          BIT_CURRENT_LIMIT       = 2;
	localparam int          BIT_VOLTAGE_SELECT      = 0;
	localparam logic [15:0] OVR_WRITABLE_MASK       = 16'h8e7d;
	localparam logic [15:0] OVR_RESET               = 16'h8e7d;  // all straps in control

	// role and stack size encodings
	typedef enum logic [1:0] {
		POS_PRIMARY     = 2'h0,
		POS_SECONDARY_1 = 2'h1,
		POS_SECONDARY_2 = 2'h2,
		POS_SECONDARY_3 = 2'h3
	} stack_position_t;

	typedef enum logic [1:0] {
		CNT_SINGLE = 2'h0,
		CNT_TWO    = 2'h1,
		CNT_THREE  = 2'h2,
		CNT_FOUR   = 2'h3
	} stack_count_t;

	// power-up sequence, gray coded along its path
	typedef enum logic [2:0] {
		ST_WAIT_NVM = 3'h0,
		ST_SETTLE   = 3'h1,
		ST_CAPTURE  = 3'h3,
		ST_APPLY    = 3'h2,
		ST_RUN      = 3'h6
	} boot_state_t;

endpackage : strap_cfg_pkg

`default_nettype wire

// >>> hw/strap_if.sv
// strap results passed from the sampler to the configuration loader
// assumes both ends sit on the system clock
`default_nettype none

interface strap_if;
	logic       capture;     // one-cycle request to freeze the straps
	logic [1:0] position;    // held stack position strap
	logic [1:0] count;       // held stack count strap
	logic       ext_fb;      // held external feedback divider strap

	modport sampler (input capture, output position, output count, output ext_fb);
	modport loader  (output capture, input position, input count, input ext_fb);
endinterface : strap_if

`default_nettype wire

// >>> hw/strap_override_stack_config.sv
// strap capture, stack role register and strap override register
// assumes an outside bus engine hands over decoded commands, and an outside
// restore engine presents the stored override word once after power-up
// strap pins are asynchronous levels; the command port sits on the system clock
//
// Overview of operation
// [R1] stack config read as one byte, code d6
// [R2] upper nibble read-only, low fields from straps
// [R3] upper nibble keeps raw count and position
// [R4] position 00 primary up to 11 third secondary
// [R5] count 00 single up to 11 four phase
// [R6] role fields read back strap sensed values
// [R7] override word read and written, code d8
// [R8] straps win over stored values by default
// [R9] override bits act only after next power-up
// [R10] bit 15 clear forces primary single phase
// [R11] bits 14 to 12 read zero, writes ignored
// [R12] bit 11 gives soft-start to the strap
// [R13] bit 10 gives fault action to the strap
// [R14] bit 9 gives bus address to the strap
// [R15] bit 6 gives light-load mode to the strap
// [R16] bit 5 gives switching frequency to the strap
// [R17] bit 2 gives current limit to the strap
// [R18] bit 0 voltage strap, unless external divider
// [R19] straps sampled once per power cycle
`default_nettype none

module strap_override_stack_config #(
	parameter int SETTLE_CYCLES = strap_cfg_pkg::STRAP_SETTLE_CYCLES
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset_n,
	input  wire logic [1:0]  i_pin_stack_position,
	input  wire logic [1:0]  i_pin_stack_count,
	input  wire logic        i_pin_ext_feedback,
	input  wire logic        i_nvm_valid,
	input  wire logic [strap_cfg_pkg::OVR_W-1:0] i_nvm_override,
	input  wire logic        i_req_valid,
	input  wire logic        i_req_write,
	input  wire logic        i_req_word,
	input  wire logic [7:0]  i_req_code,
	input  wire logic [strap_cfg_pkg::OVR_W-1:0] i_req_wdata,
	output logic             o_rsp_valid,
	output logic             o_rsp_ack,
	output logic [strap_cfg_pkg::OVR_W-1:0] o_rsp_data,
	output logic [strap_cfg_pkg::OVR_W-1:0] o_override_image,
	output logic             o_config_done,
	output logic [1:0]       o_stack_position,
	output logic [1:0]       o_stack_count,
	output logic             o_use_strap_for_role,
	output logic             o_use_strap_for_soft_start,
	output logic             o_use_strap_for_fault_action,
	output logic             o_use_strap_for_bus_addr,
	output logic             o_use_strap_for_light_load,
	output logic             o_use_strap_for_switch_freq,
	output logic             o_use_strap_for_ramp,
	output logic             o_use_strap_for_loop_gain,
	output logic             o_use_strap_for_current_limit,
	output logic             o_use_strap_for_voltage_select
);
	import strap_cfg_pkg::*;

	// settle counter wide enough to reach the last settle count
	localparam int CW = (SETTLE_CYCLES > 1) ? $clog2(SETTLE_CYCLES + 1) : 1;

	// refuse a settle count the counter cannot serve
	// a zero count would freeze the straps before the sense circuits settle
	if (SETTLE_CYCLES < 1) begin : g_bad_settle
		$error("SETTLE_CYCLES must be at least one");
	end

	// drop unsupported override bits so they always read as zero
	// masking instead of refusing lets a host write still succeed, while
	// those positions come back as zero on the next read
	function automatic logic [OVR_W-1:0] clean_override(input logic [OVR_W-1:0] v);
		return v & OVR_WRITABLE_MASK;  // [R11]
	endfunction : clean_override

	// does a request address a register with the right size and direction
	// the role byte is read-only and byte wide; the override word moves
	// as one whole word in either direction
	function automatic logic req_legal(input logic [7:0] code, input logic wr,
			input logic word);
		logic ok;
		ok = 1'b0;
		if (code == CMD_STACK_ROLE_CONFIG) begin
			ok = !wr && !word;  // [R1]
		end else if (code == CMD_STRAP_OVERRIDE) begin
			ok = word;  // [R7]
		end
		return ok;
	endfunction : req_legal

	// strap pins cross a two-stage synchroniser inside the sampler, which
	// also keeps the frozen copy for the rest of the power cycle
	strap_if straps ();

	strap_sampler u_sampler (
		.i_clk_sys            (i_clk_sys),
		.i_reset_n            (i_reset_n),
		.i_pin_stack_position (i_pin_stack_position),
		.i_pin_stack_count    (i_pin_stack_count),
		.i_pin_ext_feedback   (i_pin_ext_feedback),
		.straps               (straps)
	);

	// power-up sequencer and its settle counter
	boot_state_t         state;
	boot_state_t         next_state;
	logic [CW-1:0]       settle_cnt;
	logic [CW-1:0]       next_settle_cnt;

	// override word as the host sees it, and the copy applied at power-up
	logic [OVR_W-1:0]    override_reg;
	logic [OVR_W-1:0]    next_override_reg;
	logic [OVR_W-1:0]    active_override;
	logic [OVR_W-1:0]    next_active_override;

	// strap results and effective role, frozen at apply
	logic [3:0]          raw_stack;
	logic [3:0]          next_raw_stack;
	logic [1:0]          eff_position;
	logic [1:0]          next_eff_position;
	logic [1:0]          eff_count;
	logic [1:0]          next_eff_count;

	// applied voltage-select choice and the end of configuration
	logic                use_vsel;
	logic                next_use_vsel;
	logic                done;
	logic                next_done;

	// registered answer of the command port
	logic                rsp_valid;
	logic                next_rsp_valid;
	logic                rsp_ack;
	logic                next_rsp_ack;
	logic [OVR_W-1:0]    rsp_data;
	logic [OVR_W-1:0]    next_rsp_data;

	// combinational image of the role byte, read through the answer register
	logic [7:0]          stack_byte;

	// the freeze request is issued only in the capture step
	assign straps.capture = (state == ST_CAPTURE);  // [R19]

	// live view of the stack role register
	// the raw nibble always shows the strap copy, even while the role
	// fields are forced to primary single phase
	always_comb begin
		stack_byte = 8'h00;
		stack_byte[STK_RAW_LSB +: 4] = raw_stack;  // [R2] [R3]
		stack_byte[STK_POS_LSB +: 2] = eff_position;  // [R6]
		stack_byte[STK_CNT_LSB +: 2] = eff_count;  // [R6]
	end

	// power-up sequence: restore, settle, freeze straps, apply
	always_comb begin
		next_state           = state;
		next_settle_cnt      = settle_cnt;
		next_active_override = active_override;
		next_raw_stack       = raw_stack;
		next_eff_position    = eff_position;
		next_eff_count       = eff_count;
		next_use_vsel        = use_vsel;
		next_done            = done;
		unique case (state)
			ST_WAIT_NVM: begin
				// the stored word must be in place before anything is applied
				if (i_nvm_valid) begin
					next_state      = ST_SETTLE;
					next_settle_cnt = '0;
				end
			end
			ST_SETTLE: begin
				// give the strap sense circuits time to settle before freezing
				if (settle_cnt == CW'(SETTLE_CYCLES - 1)) begin
					next_state = ST_CAPTURE;
				end else begin
					next_settle_cnt = settle_cnt + CW'(1);
				end
			end
			ST_CAPTURE: begin
				// the sampler freezes its synchronised copy on this cycle
				next_state = ST_APPLY;
			end
			ST_APPLY: begin
				// the stored word becomes active here only, never on a later write
				next_active_override = override_reg;  // [R9]
				next_raw_stack = {straps.count, straps.position};  // [R3]
				// with the role bit clear the role straps are ignored
				if (override_reg[BIT_ROLE]) begin
					next_eff_position = straps.position;  // [R4] [R10]
					next_eff_count    = straps.count;  // [R5] [R10]
				end else begin
					next_eff_position = POS_PRIMARY;  // [R10]
					next_eff_count    = CNT_SINGLE;  // [R10]
				end
				// the voltage strap has no say once the external divider is chosen
				next_use_vsel = override_reg[BIT_VOLTAGE_SELECT] && !straps.ext_fb;  // [R18]
				next_done     = 1'b1;
				next_state    = ST_RUN;
			end
			ST_RUN: begin
				// held until the next reset, so nothing is applied twice
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_WAIT_NVM;
			end
		endcase
	end

	// override word: restored once, then written by the host
	// a host write changes only this copy; the applied copy keeps its
	// power-up value, so a new choice needs a store and a power cycle
	always_comb begin
		next_override_reg = override_reg;
		if (state == ST_WAIT_NVM && i_nvm_valid) begin
			next_override_reg = clean_override(i_nvm_override);
		end else if (state == ST_RUN && i_req_valid && i_req_write
				&& req_legal(i_req_code, i_req_write, i_req_word)) begin
			next_override_reg = clean_override(i_req_wdata);  // [R7] [R11]
		end
	end

	// one answer the cycle after each request
	// early requests, unknown codes and wrong size or direction are
	// refused with zero data
	always_comb begin
		next_rsp_valid = 1'b0;
		next_rsp_ack   = 1'b0;
		next_rsp_data  = '0;
		if (i_req_valid) begin
			next_rsp_valid = 1'b1;
			if (state == ST_RUN && req_legal(i_req_code, i_req_write, i_req_word)) begin
				next_rsp_ack = 1'b1;
				if (!i_req_write) begin
					if (i_req_code == CMD_STACK_ROLE_CONFIG) begin
						next_rsp_data = {8'h00, stack_byte};  // [R1]
					end else begin
						next_rsp_data = override_reg;  // [R7] [R11]
					end
				end
			end
		end
	end

	// state registers; the asynchronous reset stands for a power cycle,
	// so every applied value returns to its power-up default here
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state           <= ST_WAIT_NVM;
			settle_cnt      <= '0;
			override_reg    <= OVR_RESET;  // [R8]
			active_override <= OVR_RESET;  // [R8]
			raw_stack       <= STK_RAW_RESET;  // [R3]
			eff_position    <= POS_PRIMARY;
			eff_count       <= CNT_SINGLE;
			use_vsel        <= 1'b0;
			done            <= 1'b0;
			rsp_valid       <= 1'b0;
			rsp_ack         <= 1'b0;
			rsp_data        <= '0;
		end else begin
			state           <= next_state;
			settle_cnt      <= next_settle_cnt;
			override_reg    <= next_override_reg;
			active_override <= next_active_override;
			raw_stack       <= next_raw_stack;
			eff_position    <= next_eff_position;
			eff_count       <= next_eff_count;
			use_vsel        <= next_use_vsel;
			done            <= next_done;
			rsp_valid       <= next_rsp_valid;
			rsp_ack         <= next_rsp_ack;
			rsp_data        <= next_rsp_data;
		end
	end

	// outputs, each a flip-flop or a bit of one
	assign o_rsp_valid                    = rsp_valid;
	assign o_rsp_ack                      = rsp_ack;
	assign o_rsp_data                     = rsp_data;

	// word that a store would save
	assign o_override_image               = override_reg;  // word for the store engine

	// configuration state and effective role
	assign o_config_done                  = done;
	assign o_stack_position               = eff_position;
	assign o_stack_count                  = eff_count;

	// per-function strap selections from the applied word
	assign o_use_strap_for_role           = active_override[BIT_ROLE];  // [R10]
	assign o_use_strap_for_soft_start     = active_override[BIT_SOFT_START];  // [R12]
	assign o_use_strap_for_fault_action   = active_override[BIT_FAULT_ACTION];  // [R13]
	assign o_use_strap_for_bus_addr       = active_override[BIT_BUS_ADDR];  // [R14]
	assign o_use_strap_for_light_load     = active_override[BIT_LIGHT_LOAD];  // [R15]
	assign o_use_strap_for_switch_freq    = active_override[BIT_SWITCH_FREQ];  // [R16]
	assign o_use_strap_for_ramp           = active_override[BIT_RAMP];
	assign o_use_strap_for_loop_gain      = active_override[BIT_LOOP_GAIN];
	assign o_use_strap_for_current_limit  = active_override[BIT_CURRENT_LIMIT];  // [R17]
	assign o_use_strap_for_voltage_select = use_vsel;  // [R18]
endmodule : strap_override_stack_config

`default_nettype wire

// >>> hw/strap_sampler.sv
// synchronises the strap pins and freezes them on a capture request
// assumes strap pins are asynchronous levels from the sensing circuits
`default_nettype none

module strap_sampler (
	input  wire logic    i_clk_sys,
	input  wire logic    i_reset_n,
	input  wire logic [1:0] i_pin_stack_position,
	input  wire logic [1:0] i_pin_stack_count,
	input  wire logic    i_pin_ext_feedback,
	strap_if.sampler     straps
);
	import strap_cfg_pkg::*;

	logic [4:0] sync_a;
	logic [4:0] sync_b;
	logic [4:0] held;
	logic [4:0] next_held;

	// hold only changes on the capture request
	always_comb begin
		next_held = held;
		if (straps.capture) begin
			next_held = sync_b;  // [R19]
		end
	end

	// two-stage synchroniser, then the frozen copy
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync_a <= 5'h00;
			sync_b <= 5'h00;
			held   <= 5'h00;
		end else begin
			sync_a <= {i_pin_ext_feedback, i_pin_stack_count, i_pin_stack_position};
			sync_b <= sync_a;
			held   <= next_held;
		end
	end

	assign straps.position = held[1:0];
	assign straps.count    = held[3:2];
	assign straps.ext_fb   = held[4];
endmodule : strap_sampler

`default_nettype wire

// >>> verif/cmd_host.sv
// host model issuing one decoded command at a time on the command port
// assumes the loader answers on the edge after it takes a request
`default_nettype none

module cmd_host (
	input  wire logic        i_clk_sys,
	output logic             o_req_valid,
	output logic             o_req_write,
	output logic             o_req_word,
	output logic [7:0]       o_req_code,
	output logic [15:0]      o_req_wdata,
	input  wire logic        i_rsp_valid,
	input  wire logic        i_rsp_ack,
	input  wire logic [15:0] i_rsp_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle port at time zero
	initial begin
		o_req_valid = 1'b0;
		o_req_write = 1'b0;
		o_req_word = 1'b0;
		o_req_code = 8'h00;
		o_req_wdata = 16'h0000;
	end
	// one request pulse, answer taken at the following edge
	task automatic cmd(input logic wr, input logic wd, input logic [7:0] c,
		input logic [15:0] d, output logic [17:0] rsp);
		@(posedge i_clk_sys);
		o_req_valid <= 1'b1;
		o_req_write <= wr;
		o_req_word <= wd;
		o_req_code <= c;
		o_req_wdata <= d;
		@(posedge i_clk_sys);
		o_req_valid <= 1'b0;
		o_req_code <= ~c; // released fields no longer show the last request
		o_req_wdata <= ~d;
		@(posedge i_clk_sys);
		rsp = {i_rsp_valid, i_rsp_ack, i_rsp_data};
	endtask : cmd
endmodule : cmd_host

`default_nettype wire

// >>> verif/strap_cfg_chk.sv
// assertions on the command port and outputs of the strap configuration loader
// assumes one clock domain and the one-cycle answer of the command port
`default_nettype none

module strap_cfg_chk
	import strap_cfg_pkg::*;
(
	input wire logic        i_clk_sys,
	input wire logic        i_reset_n,
	input wire logic        i_req_valid,
	input wire logic        i_req_write,
	input wire logic        i_req_word,
	input wire logic [7:0]  i_req_code,
	input wire logic [15:0] i_req_wdata,
	input wire logic        o_rsp_valid,
	input wire logic        o_rsp_ack,
	input wire logic [15:0] o_rsp_data,
	input wire logic [15:0] o_override_image,
	input wire logic        o_config_done,
	input wire logic [1:0]  o_stack_position,
	input wire logic [1:0]  o_stack_count,
	input wire logic        o_use_strap_for_role,
	input wire logic        o_use_strap_for_voltage_select
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);
	// command kinds seen at the port
	sequence s_live;
		i_req_valid && o_config_done;
	endsequence
	sequence s_rd_role;
		s_live ##0 (i_req_code == CMD_STACK_ROLE_CONFIG && !i_req_write && !i_req_word);
	endsequence
	sequence s_wr_ovr;
		s_live ##0 (i_req_code == CMD_STRAP_OVERRIDE && i_req_write && i_req_word);
	endsequence
	sequence s_bad_code;
		i_req_valid ##0 (i_req_code != CMD_STACK_ROLE_CONFIG && i_req_code != CMD_STRAP_OVERRIDE);
	endsequence
	property p_hold;
		o_config_done |=> o_config_done && $stable({o_stack_position, o_stack_count,
			o_use_strap_for_role, o_use_strap_for_voltage_select});
	endproperty
	// every command answered on the next edge, and only then
	AST_ANSWER: assert property (i_req_valid |=> o_rsp_valid) else $error("no answer");
	AST_QUIET: assert property (!i_req_valid |=> !o_rsp_valid) else $error("stray answer");
	AST_EARLY: assert property (i_req_valid && !o_config_done |=> !o_rsp_ack && o_rsp_data == 16'h0)
		else $error("ack before configured");
	AST_BADCODE: assert property (s_bad_code |=> !o_rsp_ack) else $error("unknown code acked");
	AST_RSV: assert property (o_override_image[14:12] == 3'h0) else $error("reserved bits set");
	AST_ROLE_OFF: assert property (o_config_done && !o_use_strap_for_role |->
		{o_stack_position, o_stack_count} == 4'h0) else $error("role not primary single");
	AST_HOLD: assert property (p_hold) else $error("applied selection moved");
	AST_RD_ROLE: assert property (s_rd_role |=> o_rsp_ack && o_rsp_data[15:8] == 8'h0 &&
		o_rsp_data[3:0] == {o_stack_position, o_stack_count}) else $error("bad role byte");
	AST_WR_OVR: assert property (s_wr_ovr |=> o_rsp_ack &&
		o_override_image == ($past(i_req_wdata) & OVR_WRITABLE_MASK)) else $error("bad write");
endmodule : strap_cfg_chk

bind strap_override_stack_config strap_cfg_chk i_chk (.i_clk_sys, .i_reset_n, .i_req_valid,
	.i_req_write, .i_req_word, .i_req_code, .i_req_wdata, .o_rsp_valid, .o_rsp_ack, .o_rsp_data,
	.o_override_image, .o_config_done, .o_stack_position, .o_stack_count, .o_use_strap_for_role,
	.o_use_strap_for_voltage_select);

`default_nettype wire

// >>> verif/strap_override_stack_config_tb.sv
// self-checking bench for the strap configuration loader
// assumes the host model drives commands and the bench drives straps and restore
`default_nettype none

module strap_override_stack_config_tb;
	import strap_cfg_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SETTLE = 2;
	logic        i_clk_sys, i_reset_n, i_pin_ext_feedback, i_nvm_valid;
	logic [1:0]  i_pin_stack_position, i_pin_stack_count, o_stack_position, o_stack_count;
	logic [15:0] i_nvm_override, i_req_wdata, o_rsp_data, o_override_image, nv, w;
	logic        i_req_valid, i_req_write, i_req_word, o_rsp_valid, o_rsp_ack, o_config_done;
	logic [7:0]  i_req_code;
	logic        o_use_strap_for_role, o_use_strap_for_soft_start, o_use_strap_for_fault_action;
	logic        o_use_strap_for_bus_addr, o_use_strap_for_light_load, o_use_strap_for_switch_freq;
	logic        o_use_strap_for_ramp, o_use_strap_for_loop_gain, o_use_strap_for_current_limit;
	logic        o_use_strap_for_voltage_select;
	logic [17:0] r;
	logic [4:0]  pins;
	logic [9:0]  sel_seen;
	int          fail_count, tests_run;
	int          cyc = 0;  // cycle count for the hang guard, driven by that process alone

	strap_override_stack_config #(.SETTLE_CYCLES(SETTLE)) i_dut (.i_clk_sys, .i_reset_n,
		.i_pin_stack_position, .i_pin_stack_count, .i_pin_ext_feedback, .i_nvm_valid,
		.i_nvm_override, .i_req_valid, .i_req_write, .i_req_word, .i_req_code, .i_req_wdata,
		.o_rsp_valid, .o_rsp_ack, .o_rsp_data, .o_override_image, .o_config_done,
		.o_stack_position, .o_stack_count, .o_use_strap_for_role, .o_use_strap_for_soft_start,
		.o_use_strap_for_fault_action, .o_use_strap_for_bus_addr, .o_use_strap_for_light_load,
		.o_use_strap_for_switch_freq, .o_use_strap_for_ramp, .o_use_strap_for_loop_gain,
		.o_use_strap_for_current_limit, .o_use_strap_for_voltage_select);
	cmd_host i_host (.i_clk_sys, .o_req_valid(i_req_valid), .o_req_write(i_req_write),
		.o_req_word(i_req_word), .o_req_code(i_req_code), .o_req_wdata(i_req_wdata),
		.i_rsp_valid(o_rsp_valid), .i_rsp_ack(o_rsp_ack), .i_rsp_data(o_rsp_data));

	// applied selections gathered in override bit order
	assign sel_seen = {o_use_strap_for_role, o_use_strap_for_soft_start,
		o_use_strap_for_fault_action, o_use_strap_for_bus_addr, o_use_strap_for_light_load,
		o_use_strap_for_switch_freq, o_use_strap_for_ramp, o_use_strap_for_loop_gain,
		o_use_strap_for_current_limit, o_use_strap_for_voltage_select};

	function automatic logic [9:0] sel_exp(input logic [15:0] v, input logic ext);
		return {v[15], v[11], v[10], v[9], v[6], v[5], v[4], v[3], v[2], v[0] & ~ext};
	endfunction : sel_exp

	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	// power cycle with straps and a restored word, then wait for configuration
	task automatic boot(input logic [15:0] v, input logic [4:0] p);
		i_reset_n <= 1'b0;
		i_nvm_override <= v;
		{i_pin_ext_feedback, i_pin_stack_count, i_pin_stack_position} <= p;
		repeat (3) @(posedge i_clk_sys);
		chk(18'(o_override_image), 18'h08e7d);
		i_reset_n <= 1'b1;
		i_host.cmd(1'b0, 1'b0, CMD_STACK_ROLE_CONFIG, 16'h0, r);
		chk(r, 18'h20000);
		i_nvm_valid <= 1'b1;
		@(posedge i_clk_sys);
		i_nvm_valid <= 1'b0;
		repeat (SETTLE + 4) @(posedge i_clk_sys);
		chk(18'(o_config_done), 18'h1);
		chk(18'(sel_seen), 18'(sel_exp(v, p[4])));
	endtask : boot

	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	// hang guard
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			end_sim();
		end
	end

	initial begin
		{i_reset_n, i_nvm_valid, i_nvm_override, pins, w, fail_count, tests_run} = '0;
		{i_pin_ext_feedback, i_pin_stack_count, i_pin_stack_position} = 5'h00;
		void'($urandom(69980));
		for (int i = 0; i < 6; i++) begin
			// corner words first, then random words with bit 15 set, then restores of the last written word
			nv = (i == 0) ? 16'h0 : (i == 1) ? 16'hffff : (i > 3) ? w : 16'($urandom) | 16'h8000;
			pins = (i < 4) ? {1'(i), 2'(3 - i), 2'(i)} : 5'($urandom);
			boot(nv, pins);
			i_host.cmd(1'b0, 1'b0, CMD_STACK_ROLE_CONFIG, 16'h0, r);
			chk(r, {2'b11, 8'h0, pins[3:0], nv[15] ? {pins[1:0], pins[3:2]} : 4'h0});
			i_host.cmd(1'b0, 1'b1, CMD_STRAP_OVERRIDE, 16'h0, r);
			chk(r, {2'b11, nv & OVR_WRITABLE_MASK});
			w = 16'($urandom);
			i_host.cmd(1'b1, 1'b1, CMD_STRAP_OVERRIDE, w, r);
			chk(r, 18'h30000);
			chk(18'(o_override_image), 18'(w & OVR_WRITABLE_MASK));
			chk(18'(sel_seen), 18'(sel_exp(nv, pins[4])));
			i_pin_stack_position <= ~pins[1:0];
			i_pin_stack_count <= ~pins[3:2];
			repeat (4) @(posedge i_clk_sys);
			i_host.cmd(1'b0, 1'b0, CMD_STACK_ROLE_CONFIG, 16'h0, r);
			chk(r, {2'b11, 8'h0, pins[3:0], nv[15] ? {pins[1:0], pins[3:2]} : 4'h0});
			// refusals: unknown code, role write, override byte read, role word read
			for (int k = 0; k < 4; k++) begin
				i_host.cmd(k == 1, k == 0 || k == 3, (k == 0) ? 8'hd7 : (k == 2) ?
					CMD_STRAP_OVERRIDE : CMD_STACK_ROLE_CONFIG, w, r);
				chk(r, 18'h20000);
			end
			$display("test %0d done", i);
		end
		end_sim();
	end
endmodule : strap_override_stack_config_tb

`default_nettype wire
